// *** rtl/dgs_pkg.sv ***
// package: generic status byte layout, apb offsets, reset values
package dgs_pkg;
    // reply byte positions of the three status bytes
    localparam logic [7:0] REQ_BYTE_POS  = 8'h04;
    localparam logic [7:0] MODE_BYTE_POS = 8'h05;
    localparam logic [7:0] ERR_BYTE_POS  = 8'h06;
    // apb byte addresses
    localparam logic [7:0] OFF_CTRL   = 8'h00;
    localparam logic [7:0] OFF_STATUS = 8'h04;
    localparam logic [7:0] OFF_ERRSET = 8'h08;
    localparam logic [7:0] OFF_ERRCLR = 8'h0c;
    // ctrl register fields
    localparam int CTRL_ALIGN     = 0;
    localparam int CTRL_DIAGLOAD  = 1;
    localparam int CTRL_LOGWAIT   = 2;
    localparam int CTRL_SHUTOFF   = 3;
    localparam int CTRL_FMT       = 4;
    localparam int CTRL_DIAGCYL   = 5;
    localparam int CTRL_LOGINH_LO = 6;
    localparam int CTRL_LOGINH_HI = 7;
    // error byte bit positions
    localparam int ERR_UNIT  = 7;
    localparam int ERR_XMIT  = 6;
    localparam int ERR_PROTO = 5;
    localparam int ERR_INIT  = 4;
    localparam int ERR_WPROT = 3;
    localparam logic [7:0]  ERR_MASK       = 8'hf8;
    localparam logic [1:0]  LOG_INHIBIT_ON = 2'h2;
    localparam logic [7:0]  CTRL_RST       = 8'h00;
    localparam logic [7:0]  ERR_RST        = 8'h00;
    localparam logic [31:0] RDATA_RST      = 32'h0000_0000;
endpackage : dgs_pkg

// *** rtl/dgs_status.sv ***
// generic status byte assembly with apb control and error flags
// Overview of operation
// [RQ1] status goes in status and failed replies
// [RQ2] request byte 4, mode 5, error 6
// [RQ3] offline bit zero when unit available
// [RQ4] align_ask set while readjustment requested
// [RQ5] diag_load_ask set while diagnostics requested
// [RQ6] spindle_up only when storage ready
// [RQ7] log_info_waiting when extended area loggable
// [RQ8] link_b_path zero port A, one B
// [RQ9] port_swtch_in when port switch enabled
// [RQ10] spin_switch_in when run switch in
// [RQ11] log_inhibit_pair 10 disables internal logging
// [RQ12] wprot_switch reflects write protect switch
// [RQ13] shut off flag lights fault indicator
// [RQ14] fmt_allow when formatting enabled
// [RQ15] diag_cyl_allow when diagnostic cylinders enabled
// [RQ16] alt_sector_size always zero, 512 bytes
// [RQ17] unit fault flag lights fault indicator
// [RQ18] transmission fault, no fault indicator
// [RQ19] protocol fault, no fault indicator
// [RQ20] init fail flag lights fault indicator
// [RQ21] write protect violation lights fault indicator
// [RQ22] controller may log without any flag
// [RQ23] msb first, unassigned bits zero
`timescale 1ns/1ps
`default_nettype none
module dgs_status (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        unit_online_pin,
    input  wire logic        spindle_ready_pin,
    input  wire logic        link_b_pin,
    input  wire logic        port_sw_pin,
    input  wire logic        run_sw_pin,
    input  wire logic        wprot_sw_pin,
    input  wire logic        unit_fault_evt,
    input  wire logic        link_xmit_evt,
    input  wire logic        cmd_protocol_evt,
    input  wire logic        init_fail_evt,
    input  wire logic        write_cmd_evt,
    input  wire logic        status_req,
    input  wire logic        l2_failed,
    output logic      [7:0]  reply_pos,
    output logic      [7:0]  reply_byte,
    output logic             reply_valid,
    output logic             fault_led,
    output logic             int_log_enable
);
    typedef enum logic [1:0] {
        DGS_IDLE = 2'b00,
        DGS_REQ  = 2'b01,
        DGS_MODE = 2'b11,
        DGS_ERR  = 2'b10
    } dgs_state_e;

    typedef struct packed {
        logic [5:0]  sync1;
        logic [5:0]  sync2;
        logic [7:0]  ctrl;
        logic [7:0]  err;
        dgs_state_e  st;
        logic [7:0]  pos;
        logic [7:0]  byte_out;
        logic        valid;
        logic [31:0] rdata;
    } dgs_state_s;

    dgs_state_s s_q;
    dgs_state_s s_d;

    logic [7:0] req_byte;
    logic [7:0] mode_byte;
    logic       online;
    logic       spin_rdy;
    logic       port_b;
    logic       port_sw;
    logic       run_sw;
    logic       wp_sw;
    logic       acc;
    logic       wp_viol;

    function automatic logic [31:0] zext8(input logic [7:0] v);
        zext8 = {24'h00_0000, v};
    endfunction : zext8

    // pin levels read only from the second synchroniser stage
    assign online   = s_q.sync2[0];
    assign spin_rdy = s_q.sync2[1];
    assign port_b   = s_q.sync2[2];
    assign port_sw  = s_q.sync2[3];
    assign run_sw   = s_q.sync2[4];
    assign wp_sw    = s_q.sync2[5];

    always_comb
    begin
        req_byte = {~online,                          // RQ3
                    s_q.ctrl[dgs_pkg::CTRL_ALIGN],    // RQ4
                    s_q.ctrl[dgs_pkg::CTRL_DIAGLOAD], // RQ5
                    spin_rdy,                         // RQ6
                    s_q.ctrl[dgs_pkg::CTRL_LOGWAIT],  // RQ7
                    port_b,                           // RQ8
                    port_sw,                          // RQ9
                    run_sw};                          // RQ10
        mode_byte = {s_q.ctrl[dgs_pkg::CTRL_LOGINH_HI],
                     s_q.ctrl[dgs_pkg::CTRL_LOGINH_LO], // RQ11
                     1'b0,                              // RQ23
                     wp_sw,                             // RQ12
                     s_q.ctrl[dgs_pkg::CTRL_SHUTOFF],   // RQ13
                     s_q.ctrl[dgs_pkg::CTRL_FMT],       // RQ14
                     s_q.ctrl[dgs_pkg::CTRL_DIAGCYL],   // RQ15
                     1'b0};                             // RQ16
    end

    assign acc     = psel & penable;
    assign pready  = 1'b1;
    assign pslverr = 1'b0;
    assign prdata  = s_q.rdata;
    // write or format while protected
    assign wp_viol = write_cmd_evt & wp_sw; // RQ21

    always_comb
    begin
        s_d       = s_q;
        s_d.sync1 = {wprot_sw_pin, run_sw_pin, port_sw_pin, link_b_pin, spindle_ready_pin, unit_online_pin};
        s_d.sync2 = s_q.sync1;
        if (acc && pwrite)
        begin
            case (paddr)
                dgs_pkg::OFF_CTRL:   s_d.ctrl = pwdata[7:0];
                dgs_pkg::OFF_ERRSET: s_d.err  = s_q.err | (pwdata[7:0] & dgs_pkg::ERR_MASK);
                dgs_pkg::OFF_ERRCLR: s_d.err  = s_q.err & ~pwdata[7:0];
                default:             s_d.err  = s_q.err;
            endcase
        end
        // hardware set beats software clear
        if (unit_fault_evt)   s_d.err[dgs_pkg::ERR_UNIT]  = 1'b1; // RQ17
        if (link_xmit_evt)    s_d.err[dgs_pkg::ERR_XMIT]  = 1'b1; // RQ18
        if (cmd_protocol_evt) s_d.err[dgs_pkg::ERR_PROTO] = 1'b1; // RQ19
        if (init_fail_evt)    s_d.err[dgs_pkg::ERR_INIT]  = 1'b1; // RQ20
        if (wp_viol)          s_d.err[dgs_pkg::ERR_WPROT] = 1'b1; // RQ21
        s_d.err = s_d.err & dgs_pkg::ERR_MASK; // RQ23
        s_d.rdata = dgs_pkg::RDATA_RST;
        if (psel && !penable && !pwrite)
        begin
            case (paddr)
                dgs_pkg::OFF_CTRL:   s_d.rdata = zext8(s_q.ctrl);
                dgs_pkg::OFF_STATUS: s_d.rdata = {8'h00, s_q.err, mode_byte, req_byte};
                dgs_pkg::OFF_ERRSET: s_d.rdata = zext8(s_q.err);
                default:             s_d.rdata = dgs_pkg::RDATA_RST;
            endcase
        end
        // byte stream, one byte a cycle, each byte taken from live state one cycle before it shows on reply_byte
        s_d.valid = 1'b0;
        case (s_q.st)
            DGS_IDLE:
            begin
                if (status_req || l2_failed) // RQ1
                begin
                    s_d.st       = DGS_REQ;
                    s_d.pos      = dgs_pkg::REQ_BYTE_POS; // RQ2
                    s_d.byte_out = req_byte;
                    s_d.valid    = 1'b1;
                end
            end
            DGS_REQ:
            begin
                s_d.st       = DGS_MODE;
                s_d.pos      = dgs_pkg::MODE_BYTE_POS; // RQ2
                s_d.byte_out = mode_byte;
                s_d.valid    = 1'b1;
            end
            DGS_MODE:
            begin
                s_d.st       = DGS_ERR;
                s_d.pos      = dgs_pkg::ERR_BYTE_POS; // RQ2
                s_d.byte_out = s_q.err;
                s_d.valid    = 1'b1;
            end
            DGS_ERR:
            begin
                s_d.st = DGS_IDLE;
            end
            default:
            begin
                s_d.st = DGS_IDLE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s_q.sync1    <= 6'h00;
            s_q.sync2    <= 6'h00;
            s_q.ctrl     <= dgs_pkg::CTRL_RST;
            s_q.err      <= dgs_pkg::ERR_RST;
            s_q.st       <= DGS_IDLE;
            s_q.pos      <= 8'h00;
            s_q.byte_out <= 8'h00;
            s_q.valid    <= 1'b0;
            s_q.rdata    <= dgs_pkg::RDATA_RST;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign reply_pos   = s_q.pos;
    assign reply_byte  = s_q.byte_out;
    assign reply_valid = s_q.valid;
    // transmission and protocol faults keep the light off
    assign fault_led = s_q.ctrl[dgs_pkg::CTRL_SHUTOFF] | s_q.err[dgs_pkg::ERR_UNIT]
                     | s_q.err[dgs_pkg::ERR_INIT] | s_q.err[dgs_pkg::ERR_WPROT]; // RQ13 RQ17 RQ20 RQ21
    assign int_log_enable = ({s_q.ctrl[dgs_pkg::CTRL_LOGINH_HI], s_q.ctrl[dgs_pkg::CTRL_LOGINH_LO]}
                             != dgs_pkg::LOG_INHIBIT_ON); // RQ11
endmodule : dgs_status
`default_nettype wire

// *** testbench/dgs_chk_props.sv ***
// checker on status bursts, fault light and apb read data
`timescale 1ns/1ps
`default_nettype none
module dgs_chk (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] prdata,
    input wire logic        unit_fault_evt,
    input wire logic        status_req,
    input wire logic [7:0]  reply_pos,
    input wire logic [7:0]  reply_byte,
    input wire logic        reply_valid,
    input wire logic        fault_led,
    input wire logic        int_log_enable
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire logic wr = psel && penable && pwrite;
    sequence burst_s;
        reply_valid && reply_pos == 8'h04 ##1 reply_valid && reply_pos == 8'h05 ##1 reply_valid && reply_pos == 8'h06;
    endsequence
    burst_order_a: assert property (status_req && !reply_valid && !$past(reply_valid) && !$past(status_req)
        |=> burst_s ##1 !reply_valid) else $error("bad status burst");
    pos_range_a: assert property (reply_valid |-> reply_pos inside {8'h04, 8'h05, 8'h06})
        else $error("bad reply position");
    mode_pad_a: assert property (reply_valid && reply_pos == 8'h05 |-> !reply_byte[5] && !reply_byte[0])
        else $error("mode pad bit set");
    err_pad_a: assert property (reply_valid && reply_pos == 8'h06 |-> reply_byte[2:0] == 3'h0)
        else $error("error pad bit set");
    fault_lit_a: assert property (unit_fault_evt |=> fault_led) else $error("fault light off");
    led_fall_a: assert property ($fell(fault_led) |-> $past(wr)) else $error("fault light dropped");
    rdata_idle_a: assert property (!(psel && penable) |-> prdata == 32'h0) else $error("stray read data");
    log_hold_a: assert property ($changed(int_log_enable) |-> $past(wr && paddr == 8'h00))
        else $error("log enable moved");
endmodule : dgs_chk
bind dgs_status dgs_chk u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .prdata, .unit_fault_evt,
    .status_req, .reply_pos, .reply_byte, .reply_valid, .fault_led, .int_log_enable);
`default_nettype wire

// *** testbench/dgs_host.sv ***
// storage controller model: asks for status, keeps the three bytes
`timescale 1ns/1ps
`default_nettype none
module dgs_host (
    input  wire logic       pclk,
    output logic            status_req,
    output logic            l2_failed,
    input  wire logic [7:0] reply_pos,
    input  wire logic [7:0] reply_byte,
    input  wire logic       reply_valid
);
    logic [7:0] got [3];
    initial {status_req, l2_failed} = 2'b00;
    // bytes kept whatever the error flags say
    always @(posedge pclk)
        if (reply_valid && reply_pos inside {[8'h04:8'h06]})
            got[reply_pos - 8'h04] <= reply_byte;
    // stale bytes wiped so a missing burst cannot pass
    task ask(input logic fail);
        got = '{8'hxx, 8'hxx, 8'hxx};
        @(posedge pclk) {status_req, l2_failed} <= {!fail, fail};
        @(posedge pclk) {status_req, l2_failed} <= 2'b00;
        repeat (5) @(posedge pclk);
    endtask : ask
endmodule : dgs_host
`default_nettype wire

// *** testbench/testbench.sv ***
// self-checking bench for generic status assembly
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin n_errors++; $display("[FAIL] %0t %h %h", $time, a, b); end end
module testbench;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic        pready, pslverr, status_req, l2_failed, reply_valid, fault_led, int_log_enable;
    logic [4:0]  evt = 5'h00;
    logic [5:0]  pins = 6'h00;
    logic [7:0]  paddr = 8'h00, reply_pos, reply_byte;
    logic [31:0] pwdata = 32'h0, prdata, r;
    int          n_errors = 0, tests_run = 0, cyc = 0;
    typedef struct {logic [5:0] pins; logic [7:0] ctrl, req, mode; logic ile, led;} dgs_row_s;
    // pins: online, spindle, port b, port sw, run sw, wprot
    dgs_row_s    rows [3] = '{'{6'h00, 8'h00, 8'h80, 8'h00, 1'b1, 1'b0}, '{6'h3f, 8'hbf, 8'h7f, 8'h9e, 1'b0, 1'b1},
                             '{6'h2a, 8'h45, 8'h4d, 8'h40, 1'b1, 1'b0}};
    always #12.5 pclk = ~pclk;
    always @(posedge pclk) if (++cyc == 3000) begin n_errors++; results(); end
    dgs_status dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .unit_online_pin(pins[5]), .spindle_ready_pin(pins[4]), .link_b_pin(pins[3]), .port_sw_pin(pins[2]),
        .run_sw_pin(pins[1]), .wprot_sw_pin(pins[0]), .unit_fault_evt(evt[4]), .link_xmit_evt(evt[3]),
        .cmd_protocol_evt(evt[2]), .init_fail_evt(evt[1]), .write_cmd_evt(evt[0]), .status_req, .l2_failed,
        .reply_pos, .reply_byte, .reply_valid, .fault_led, .int_log_enable);
    dgs_host host (.pclk, .status_req, .l2_failed, .reply_pos, .reply_byte, .reply_valid);
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk) {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge pclk) penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        {psel, penable} <= 2'b00;
    endtask : apb
    task results;
        $display("compares %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : results
    initial
    begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        `CHK({int_log_enable, fault_led}, 2'h2)
        foreach (rows[i])
        begin
            pins <= rows[i].pins;
            apb(1'b1, dgs_pkg::OFF_CTRL, {24'h0, rows[i].ctrl});
            host.ask(1'b0);
            `CHK(host.got[0], rows[i].req)
            `CHK(host.got[1], rows[i].mode)
            `CHK(host.got[2], 8'h00)
            `CHK({int_log_enable, fault_led}, {rows[i].ile, rows[i].led})
            $display("row %0d done", i);
        end
        for (int i = 0; i < 4; i++)
        begin
            @(posedge pclk) evt[4 - i] <= 1'b1;
            @(posedge pclk) evt <= 5'h00;
            apb(1'b0, dgs_pkg::OFF_ERRSET, 32'h0);
            `CHK({fault_led, r[7:0]}, {i == 0 || i == 3, 8'h80 >> i})
            apb(1'b1, dgs_pkg::OFF_ERRCLR, 32'hf8);
            $display("error class %0d done", i);
        end
        pins <= 6'h01;
        repeat (3) @(posedge pclk);
        evt[0] <= 1'b1;
        @(posedge pclk) evt <= 5'h00;
        host.ask(1'b1);
        `CHK({fault_led, host.got[2]}, {1'b1, 8'h08})
        apb(1'b0, 8'h10, 32'h0);
        `CHK({pready, pslverr, r}, {2'b10, 32'h0})
        $display("write protect and unmapped done");
        // write-1-set keeps only the five class bits
        apb(1'b1, dgs_pkg::OFF_ERRSET, 32'h24);
        apb(1'b0, dgs_pkg::OFF_STATUS, 32'h0);
        `CHK(r, 32'h0028_50c8)
        $display("status word done");
        apb(1'b1, dgs_pkg::OFF_CTRL, 32'h80);
        // ctrl lands at the access edge, so look one edge later
        @(posedge pclk) `CHK(int_log_enable, 1'b0)
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        host.ask(1'b0);
        `CHK({int_log_enable, fault_led, host.got[2]}, {2'h2, 8'h00})
        $display("mid-run reset done");
        results();
    end
endmodule : testbench
`default_nettype wire
